// ==== inc/ppbc_pkg.sv ====
package ppbc_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_BASIC_CONTROL = 12'h04c;
  localparam logic [11:0] IDX_BASIC_STATUS  = 12'h04e;
  localparam logic [11:0] IDX_IDENT_LOW     = 12'h050;
  localparam logic [11:0] IDX_IDENT_HIGH    = 12'h052;
  localparam logic [11:0] IDX_CONTROL_FOUR  = 12'h060;
  localparam logic [11:0] IDX_STATUS_ALIAS  = 12'h062;
  localparam logic [11:0] ADDR_BASIC_CONTROL = IDX_BASIC_CONTROL << 2;
  localparam logic [11:0] ADDR_BASIC_STATUS  = IDX_BASIC_STATUS << 2;
  localparam logic [11:0] ADDR_IDENT_LOW     = IDX_IDENT_LOW << 2;
  localparam logic [11:0] ADDR_IDENT_HIGH    = IDX_IDENT_HIGH << 2;
  localparam logic [11:0] ADDR_CONTROL_FOUR  = IDX_CONTROL_FOUR << 2;
  localparam logic [11:0] ADDR_STATUS_ALIAS  = IDX_STATUS_ALIAS << 2;

  // ---------------------------------------------------------------
  // Basic control fields
  // ---------------------------------------------------------------
  localparam int CTL_FAR_LOOP   = 14;
  localparam int CTL_SPEED_100  = 13;
  localparam int CTL_AN_ENABLE  = 12;
  localparam int CTL_POWER_DOWN = 11;
  localparam int CTL_ISOLATE    = 10;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX     = 8;
  localparam int CTL_COL_TEST   = 7;
  localparam int CTL_XOVER_ALG  = 5;
  localparam int CTL_FORCE_MDIX = 4;
  localparam int CTL_AUTO_DIS   = 3;
  localparam int CTL_TX_DIS     = 1;
  localparam logic [15:0] CTL_RESET = 16'h3120;
  localparam logic [15:0] CTL_WMASK = 16'h7b3f;

  // Control bit -> control_four bit, -1 where no alias
  localparam int CF_MAP [16] = '{-1, 14, 12, 10, 9, -1, -1, -1,
                                  5, 13, -1, 11, 7, 6, 8, -1};

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam logic [15:0] STS_FIXED   = 16'h7808;
  localparam int          STS_AN_DONE = 5;
  localparam int          STS_LINK    = 2;
  localparam int          SA_XOVER    = 15;
  localparam int          SA_AN_DONE  = 6;
  localparam int          SA_LINK     = 5;

  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ppbc_pkg

// ==== rtl/ppbc_top.sv ====
module ppbc_top #(
  parameter logic [15:0] PHY_ID_LOW  = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] PHY_ID_HIGH = 16'h05a5  // Arbitrary value
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        phy_an_done,
  input  wire logic        phy_link_up,
  output logic             far_loop_o,
  output logic             speed_100_o,
  output logic             an_enable_o,
  output logic             power_down_o,
  output logic             an_restart_o,
  output logic             duplex_full_o,
  output logic             xover_std_o,
  output logic             force_mdix_o,
  output logic             auto_mdix_dis_o,
  output logic             tx_disable_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic        aw_have_r;
  logic [11:0] aw_addr_r;
  logic        w_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic [1:0]  an_sync_r;
  logic [1:0]  link_sync_r;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        wr_commit;
  logic        aw_have_nxt;
  logic        w_have_nxt;
  logic        bvalid_nxt;
  logic [1:0]  bresp_nxt;
  logic        rvalid_nxt;
  logic        wr_basic;
  logic        wr_four;
  logic        wr_salias;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] ctl_view;
  logic [15:0] sts_view;
  logic [15:0] cf_view;
  logic [15:0] sa_view;
  logic [15:0] rd_word;
  logic        an_done_s;
  logic        link_s;

  // ---------------------------------------------------------------
  // Write channel decode
  // ---------------------------------------------------------------
  // Address and data may arrive in either order
  assign aw_hs       = s_axi_awvalid && awready_r;
  assign w_hs        = s_axi_wvalid && wready_r;
  assign ar_hs       = s_axi_arvalid && arready_r;
  assign wr_commit   = aw_have_r && w_have_r && !bvalid_r;
  assign aw_have_nxt = aw_hs || (aw_have_r && !wr_commit);
  assign w_have_nxt  = w_hs || (w_have_r && !wr_commit);
  assign bvalid_nxt  = wr_commit || (bvalid_r && !s_axi_bready);
  // Answer code clears with bvalid so a stale error never shows
  assign bresp_nxt   = wr_commit  ? (wr_hit ? ppbc_pkg::RESP_OKAY
                                            : ppbc_pkg::RESP_SLVERR) :
                       bvalid_nxt ? bresp_r : ppbc_pkg::RESP_OKAY;
  assign wr_basic    = wr_commit && (aw_addr_r == ppbc_pkg::ADDR_BASIC_CONTROL);
  assign wr_four     = wr_commit && (aw_addr_r == ppbc_pkg::ADDR_CONTROL_FOUR);
  assign wr_salias   = wr_commit && (aw_addr_r == ppbc_pkg::ADDR_STATUS_ALIAS);
  // Read-only words accept the write with no effect
  assign wr_hit = wr_basic || wr_four || wr_salias
               || (aw_addr_r == ppbc_pkg::ADDR_BASIC_STATUS)
               || (aw_addr_r == ppbc_pkg::ADDR_IDENT_LOW)
               || (aw_addr_r == ppbc_pkg::ADDR_IDENT_HIGH);

  // Write handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= ppbc_pkg::RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= !aw_have_nxt && !bvalid_nxt;
      wready_r  <= !w_have_nxt && !bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // Captured payloads, no reset needed
  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      aw_addr_r <= s_axi_awaddr;
    end
    if (w_hs) begin
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  // ---------------------------------------------------------------
  // Status input synchronisers
  // ---------------------------------------------------------------
  // PHY status comes from the analog side, so it is resynchronised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      an_sync_r   <= 2'b00;
      link_sync_r <= 2'b00;
    end else begin
      an_sync_r   <= {an_sync_r[0], phy_an_done};
      link_sync_r <= {link_sync_r[0], phy_link_up};
    end
  end
  assign an_done_s = an_sync_r[1];
  assign link_s    = link_sync_r[1];

  // ---------------------------------------------------------------
  // Control storage, one flop per bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_ctl
      logic basic_we;
      logic alias_we;
      logic alias_val;
      assign basic_we = wr_basic && w_strb_r[gi / 8]
                     && ppbc_pkg::CTL_WMASK[gi];
      if (ppbc_pkg::CF_MAP[gi] >= 0) begin : g_cf
        assign alias_we  = wr_four && w_strb_r[ppbc_pkg::CF_MAP[gi] / 8];
        assign alias_val = w_data_r[ppbc_pkg::CF_MAP[gi]];
      end else if (gi == ppbc_pkg::CTL_XOVER_ALG) begin : g_sa
        // crossover select shared with status alias
        assign alias_we  = wr_salias && w_strb_r[ppbc_pkg::SA_XOVER / 8];
        assign alias_val = w_data_r[ppbc_pkg::SA_XOVER];
      end else begin : g_none
        assign alias_we  = 1'b0;
        assign alias_val = 1'b0;
      end
      if (gi == ppbc_pkg::CTL_AN_RESTART) begin : g_sc
        // self-clear, a new write of one wins
        assign ctl_nxt[gi] = (basic_we && w_data_r[gi])
                          || (alias_we && alias_val);
      end else begin : g_rw
        assign ctl_nxt[gi] = basic_we ? w_data_r[gi] :
                             alias_we ? alias_val : ctl_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= ppbc_pkg::CTL_RESET;
    end else begin
      ctl_r <= ctl_nxt & ppbc_pkg::CTL_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // Control outputs to the PHY
  // ---------------------------------------------------------------
  // loopback control
  assign far_loop_o      = ctl_r[ppbc_pkg::CTL_FAR_LOOP];
  // forced speed, used only without negotiation
  assign speed_100_o     = ctl_r[ppbc_pkg::CTL_SPEED_100];
  assign an_enable_o     = ctl_r[ppbc_pkg::CTL_AN_ENABLE];
  assign power_down_o    = ctl_r[ppbc_pkg::CTL_POWER_DOWN];
  assign an_restart_o    = ctl_r[ppbc_pkg::CTL_AN_RESTART];
  // forced duplex, also the fallback when negotiation fails
  assign duplex_full_o   = ctl_r[ppbc_pkg::CTL_DUPLEX];
  assign xover_std_o     = ctl_r[ppbc_pkg::CTL_XOVER_ALG];
  assign force_mdix_o    = ctl_r[ppbc_pkg::CTL_FORCE_MDIX];
  assign auto_mdix_dis_o = ctl_r[ppbc_pkg::CTL_AUTO_DIS];
  assign tx_disable_o    = ctl_r[ppbc_pkg::CTL_TX_DIS];

  // ---------------------------------------------------------------
  // Read views
  // ---------------------------------------------------------------
  // unsupported bits never stored, so they read zero
  assign ctl_view = ctl_r & ppbc_pkg::CTL_WMASK;

  always_comb begin
    sts_view = ppbc_pkg::STS_FIXED;
    sts_view[ppbc_pkg::STS_AN_DONE] = an_done_s;
    sts_view[ppbc_pkg::STS_LINK]    = link_s;
  end

  // control_four view of the same flops
  always_comb begin
    cf_view = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (ppbc_pkg::CF_MAP[i] >= 0) begin
        cf_view[ppbc_pkg::CF_MAP[i]] = ctl_r[i];
      end
    end
  end

  always_comb begin
    sa_view = 16'h0000;
    sa_view[ppbc_pkg::SA_XOVER]   = ctl_r[ppbc_pkg::CTL_XOVER_ALG];
    sa_view[ppbc_pkg::SA_AN_DONE] = an_done_s;
    sa_view[ppbc_pkg::SA_LINK]    = link_s;
  end

  assign rd_hit = (s_axi_araddr == ppbc_pkg::ADDR_BASIC_CONTROL)
               || (s_axi_araddr == ppbc_pkg::ADDR_BASIC_STATUS)
               || (s_axi_araddr == ppbc_pkg::ADDR_IDENT_LOW)
               || (s_axi_araddr == ppbc_pkg::ADDR_IDENT_HIGH)
               || (s_axi_araddr == ppbc_pkg::ADDR_CONTROL_FOUR)
               || (s_axi_araddr == ppbc_pkg::ADDR_STATUS_ALIAS);
  assign rd_word =
    (s_axi_araddr == ppbc_pkg::ADDR_BASIC_CONTROL) ? ctl_view :
    (s_axi_araddr == ppbc_pkg::ADDR_BASIC_STATUS)  ? sts_view :
    (s_axi_araddr == ppbc_pkg::ADDR_IDENT_LOW)     ? PHY_ID_LOW :
    (s_axi_araddr == ppbc_pkg::ADDR_IDENT_HIGH)    ? PHY_ID_HIGH :
    (s_axi_araddr == ppbc_pkg::ADDR_CONTROL_FOUR)  ? cf_view :
    (s_axi_araddr == ppbc_pkg::ADDR_STATUS_ALIAS)  ? sa_view : 16'h0000;
  assign rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready);

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  // Data is sampled at the address edge and held while stalled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= ppbc_pkg::RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= {16'h0000, rd_word};
        rresp_r <= rd_hit ? ppbc_pkg::RESP_OKAY : ppbc_pkg::RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // defaults after reset
  ctl_reset_a: assert property (
    @(posedge aclk) !aresetn |=> ctl_r == ppbc_pkg::CTL_RESET)
    else $error("control defaults wrong after reset");

  restart_pulse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(an_restart_o) |=> !an_restart_o)
    else $error("restart bit did not self-clear");

  // basic write reaches power-down next cycle
  pdown_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_basic && w_strb_r[1] |=> power_down_o == $past(w_data_r[11]))
    else $error("power-down not updated by write");

  // unsupported isolate and collision-test control bits read back zero
  ro_ctl_zero_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_hs && s_axi_araddr == ppbc_pkg::ADDR_BASIC_CONTROL
    |=> !s_axi_rdata[ppbc_pkg::CTL_ISOLATE]
        && !s_axi_rdata[ppbc_pkg::CTL_COL_TEST])
    else $error("unsupported control bit set");

  sts_fixed_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sts_view & 16'hffdb) == 16'h7808)
    else $error("fixed status bits wrong");

  // link bit tracks the pin two cycles late
  link_track_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##2 sts_view[ppbc_pkg::STS_LINK] == $past(phy_link_up, 2))
    else $error("link status does not follow link");

  an_track_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##2 sa_view[ppbc_pkg::SA_AN_DONE] == $past(phy_an_done, 2))
    else $error("negotiation complete not reported");

  // write through control_four lands in shared flop
  alias_four_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_four && w_strb_r[1] && !wr_basic
    |=> far_loop_o == $past(w_data_r[8]))
    else $error("control_four alias not shared");

  id_read_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_hs && s_axi_araddr == ppbc_pkg::ADDR_IDENT_LOW
    |=> s_axi_rvalid && s_axi_rdata == {16'h0000, PHY_ID_LOW})
    else $error("identifier low word wrong");

  // Write answer one cycle after both halves held
  wr_answer_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_commit |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write response missing");

endmodule : ppbc_top

// ==== verification/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Clock, reset and design inputs
  // ---------------------------------------------------------------
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        rready;
  logic        an_done;
  logic        link_up;
  logic        awready;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic [15:0] pins;
  int          bad_count;
  int          check_count;
  int          pulse_count;

  localparam logic [1:0] OK = ppbc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ppbc_pkg::RESP_SLVERR;

  ppbc_top i_ppbc_top (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (awaddr),
    .s_axi_awprot   (3'h0),
    .s_axi_awvalid  (awvalid),
    .s_axi_awready  (awready),
    .s_axi_wdata    (wdata),
    .s_axi_wstrb    (wstrb),
    .s_axi_wvalid   (wvalid),
    .s_axi_wready   (wready),
    .s_axi_bresp    (bresp),
    .s_axi_bvalid   (bvalid),
    .s_axi_bready   (bready),
    .s_axi_araddr   (araddr),
    .s_axi_arprot   (3'h0),
    .s_axi_arvalid  (arvalid),
    .s_axi_arready  (arready),
    .s_axi_rdata    (rdata),
    .s_axi_rresp    (rresp),
    .s_axi_rvalid   (rvalid),
    .s_axi_rready   (rready),
    .phy_an_done    (an_done),
    .phy_link_up    (link_up),
    .far_loop_o     (pins[14]),
    .speed_100_o    (pins[13]),
    .an_enable_o    (pins[12]),
    .power_down_o   (pins[11]),
    .an_restart_o   (pins[9]),
    .duplex_full_o  (pins[8]),
    .xover_std_o    (pins[5]),
    .force_mdix_o   (pins[4]),
    .auto_mdix_dis_o(pins[3]),
    .tx_disable_o   (pins[1])
  );

  // Unused pin positions read zero so pins compare against control
  assign pins[15] = 1'b0;
  assign pins[10] = 1'b0;
  assign pins[7:6] = 2'h0;
  assign pins[2] = 1'b0;
  assign pins[0] = 1'b0;

  // Half-period toggle gives 100 MHz
  always #5 aclk = ~aclk;

  // Restart pulse width is counted over whole cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulse_count <= 0;
    end else if (pins[9] === 1'b1) begin
      pulse_count <= pulse_count + 1;
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Offers address and data together; bready held until answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, bresp});
    // Idle edge so the next call never re-drives bready at once
    @(posedge aclk);
  endtask : wr

  // Reads one word, compares data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    chk("read data", ed, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
    // Idle edge so the next call never re-drives rready at once
    @(posedge aclk);
  endtask : rd

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("pins after reset", 32'h3120, {16'h0, pins});
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h3120, OK);
    rd(ppbc_pkg::ADDR_BASIC_STATUS, 32'h7808, OK);
    rd(ppbc_pkg::ADDR_IDENT_LOW, 32'h0a5a, OK);
    rd(ppbc_pkg::ADDR_IDENT_HIGH, 32'h05a5, OK);
  endtask : t_reset

  // All ones: read-only zeros stay, restart clears itself
  task automatic t_ctl;
    wr(ppbc_pkg::ADDR_BASIC_CONTROL, 32'hffff, 4'h3, OK);
    chk("pins all set", 32'h793a, {16'h0, pins});
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h793f, OK);
    repeat (2) @(posedge aclk);
    chk("restart pulse", 32'h1, pulse_count);
    wr(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h0000, 4'h3, OK);
    chk("pins all clear", 32'h0, {16'h0, pins});
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h0000, OK);
    wr(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h1000, 4'h3, OK);
    chk("pins negotiate half", 32'h1000, {16'h0, pins});
  endtask : t_ctl

  // Shared storage through the per-port aliases
  task automatic t_alias;
    wr(ppbc_pkg::ADDR_CONTROL_FOUR, 32'h4100, 4'h3, OK);
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h4002, OK);
    wr(ppbc_pkg::ADDR_STATUS_ALIAS, 32'h8000, 4'h3, OK);
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h4022, OK);
    wr(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h0ff0, 4'h2, OK);
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h0922, OK);
    rd(ppbc_pkg::ADDR_CONTROL_FOUR, 32'h4820, OK);
  endtask : t_alias

  // Status follows the synchronised inputs
  task automatic t_status;
    an_done <= 1'b1;
    link_up <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(ppbc_pkg::ADDR_BASIC_STATUS, 32'h782c, OK);
    rd(ppbc_pkg::ADDR_STATUS_ALIAS, 32'h8060, OK);
    link_up <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(ppbc_pkg::ADDR_BASIC_STATUS, 32'h7828, OK);
    an_done <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(ppbc_pkg::ADDR_BASIC_STATUS, 32'h7808, OK);
  endtask : t_status

  // Read-only words keep their value, unmapped places refuse
  task automatic t_refuse;
    wr(ppbc_pkg::ADDR_BASIC_STATUS, 32'h0000, 4'h3, OK);
    rd(ppbc_pkg::ADDR_BASIC_STATUS, 32'h7808, OK);
    wr(ppbc_pkg::ADDR_IDENT_LOW, 32'hffff, 4'h3, OK);
    rd(ppbc_pkg::ADDR_IDENT_LOW, 32'h0a5a, OK);
    wr(12'h004, 32'hffff, 4'h3, ER);
    rd(12'h004, 32'h0, ER);
    rd(ppbc_pkg::ADDR_BASIC_CONTROL, 32'h0922, OK);
  endtask : t_refuse

  // ---------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Whole run needs about 130 cycles; generous margin
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {an_done, link_up} = '0;
    bad_count = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_ctl();
    t_alias();
    t_status();
    t_refuse();
    end_of_test();
  end
endmodule : tb_top
